// ### design/auto_mode_framer.sv
// Contract
// - Retry transaction reports busy retry transmit
// - Good ack: transmit end, back to idle
// - Result success, or more-data if pending set
// - Only masked-in interrupts are signalled
// - Receive start on valid length header
// - Address match interrupt on filter match
// - Receive end needs filter pass and FCS
// - Auto ack completion gives transmit end
// - Retry mode: one transmit end per transaction
// - Ack frames raise no receive interrupts
// - Off to automatic idle raises lock
// - Send four zero octets then 0xa7
// - Buffer read progressively during transmit
// - Delimiter marks start of length header
// - Length in low seven bits, msb zero
// - Received header read first, msb zero
// - Payload 0 to 127, FCS last two
// - Zero length header raises no interrupt
// - Length classes: reserved, ack, MPDU; code treats only length 0 as reserved, all other non-ack lengths as MPDU
// - Result codes; entering retry mode sets invalid
// - Frame control bit 5 decides ack wait
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module auto_mode_framer #(
  parameter int ACK_WAIT_CYCLES = auto_mode_framer_pkg::ACK_WAIT_CYCLES,
  parameter int MAX_FRAME_RETRIES = auto_mode_framer_pkg::MAX_FRAME_RETRIES_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [7:0] tx_octet,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic rx_sfd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_octet,
  input wire logic rx_end,
  input wire logic rx_fcs_ok,
  input wire logic rx_addr_match,
  input wire logic ack_tx_done,
  output logic synth_lock_irq,
  output logic receive_start_irq,
  output logic address_match_irq,
  output logic receive_end_irq,
  output logic transmit_end_irq
);
  localparam int TW = $clog2(ACK_WAIT_CYCLES + 1);

  if (ACK_WAIT_CYCLES < 1 || MAX_FRAME_RETRIES < 0 || MAX_FRAME_RETRIES > 15) begin : g_check
    $error("auto_mode_framer: parameter out of range");
  end

  typedef struct packed {
    auto_mode_framer_pkg::radio_state_t state;
    logic [127:0][7:0] mem;
    logic [4:0] mask;
    logic [2:0] result;
    logic [7:0] cnt;
    logic [7:0] tx_octet;
    logic tx_last;
    logic [3:0] retry;
    logic [TW-1:0] timer;
    logic [6:0] rx_len;
    logic [7:0] rx_fcf;
    logic matched;
    logic [4:0] irq;
    logic [7:0] rdata;
  } framer_state_t;

  framer_state_t s;
  framer_state_t next_s;
  logic [4:0] event_raw;
  logic [6:0] tx_len;
  logic ack_req;
  logic rx_is_ack;
  logic [7:0] report;

  assign tx_len = s.mem[0][6:0];
  assign ack_req = s.mem[1][auto_mode_framer_pkg::FCF_ACK_REQ_BIT];
  assign rx_is_ack = (s.rx_len == auto_mode_framer_pkg::LEN_ACK);

  always_comb begin
    case (s.state)
      auto_mode_framer_pkg::st_rx_idle: report = auto_mode_framer_pkg::REPORT_RX_IDLE;
      auto_mode_framer_pkg::st_rx_busy: report = auto_mode_framer_pkg::REPORT_RX_BUSY;
      auto_mode_framer_pkg::st_tx_idle: report = auto_mode_framer_pkg::REPORT_TX_IDLE;
      auto_mode_framer_pkg::st_tx_shr,
      auto_mode_framer_pkg::st_tx_body,
      auto_mode_framer_pkg::st_tx_ack_wait: report = auto_mode_framer_pkg::REPORT_TX_BUSY;
      default: report = auto_mode_framer_pkg::REPORT_OFF;
    endcase
  end

  always_comb begin
    next_s = s;
    event_raw = '0;
    next_s.rdata = '0;

    if (reg_rd) begin
      if (reg_addr[auto_mode_framer_pkg::FBUF_SELECT_BIT]) begin
        next_s.rdata = s.mem[reg_addr[6:0]];
      end else if (reg_addr == auto_mode_framer_pkg::ADDR_STATE_REPORT) begin
        next_s.rdata = report;
      end else if (reg_addr == auto_mode_framer_pkg::ADDR_RESULT) begin
        next_s.rdata = {5'h00, s.result};
      end else if (reg_addr == auto_mode_framer_pkg::ADDR_IRQ_MASK) begin
        next_s.rdata = {3'h0, s.mask};
      end
    end

    // Software may fill the buffer while the header goes out
    if (reg_wr && reg_addr[auto_mode_framer_pkg::FBUF_SELECT_BIT]) begin
      next_s.mem[reg_addr[6:0]] = reg_wdata;
    end else if (reg_wr && reg_addr == auto_mode_framer_pkg::ADDR_IRQ_MASK) begin
      next_s.mask = reg_wdata[4:0];
    end

    case (s.state)
      auto_mode_framer_pkg::st_rx_idle,
      auto_mode_framer_pkg::st_rx_busy: begin
        if (ack_tx_done) begin
          event_raw[auto_mode_framer_pkg::IRQ_TX_END] = 1'b1;
        end
        if (rx_sfd) begin
          next_s.state = auto_mode_framer_pkg::st_rx_busy;
          next_s.cnt = '0;
          next_s.matched = 1'b0;
          next_s.rx_len = '0;
        end else if (s.state == auto_mode_framer_pkg::st_rx_busy) begin
          if (rx_valid) begin
            if (s.cnt == 8'h00) begin
              next_s.rx_len = rx_octet[6:0];
              next_s.mem[0] = rx_octet & auto_mode_framer_pkg::LEN_MASK;
              if (rx_octet[6:0] == auto_mode_framer_pkg::LEN_INVALID) begin
                next_s.state = auto_mode_framer_pkg::st_rx_idle;
              end else if (rx_octet[6:0] != auto_mode_framer_pkg::LEN_ACK) begin
                event_raw[auto_mode_framer_pkg::IRQ_RX_START] = 1'b1;
              end
            end else begin
              next_s.mem[s.cnt[6:0]] = rx_octet;
            end
            if (s.cnt[6:0] != auto_mode_framer_pkg::LEN_MAX) begin
              next_s.cnt = 8'(s.cnt + 8'h01);
            end
          end
          if (rx_addr_match && !rx_is_ack && s.cnt != 8'h00) begin
            event_raw[auto_mode_framer_pkg::IRQ_ADDR_MATCH] = 1'b1;
            next_s.matched = 1'b1;
          end
          if (rx_end) begin
            if (s.matched && rx_fcs_ok && !rx_is_ack) begin
              event_raw[auto_mode_framer_pkg::IRQ_RX_END] = 1'b1;
            end
            next_s.state = auto_mode_framer_pkg::st_rx_idle;
          end
        end
      end
      auto_mode_framer_pkg::st_tx_shr: begin
        if (tx_ready) begin
          if (s.cnt < auto_mode_framer_pkg::PREAMBLE_OCTETS - 8'h01) begin
            next_s.tx_octet = auto_mode_framer_pkg::PREAMBLE_OCTET;
            next_s.cnt = 8'(s.cnt + 8'h01);
          end else if (s.cnt == auto_mode_framer_pkg::PREAMBLE_OCTETS - 8'h01) begin
            next_s.tx_octet = auto_mode_framer_pkg::SFD_OCTET;
            next_s.cnt = 8'(s.cnt + 8'h01);
          end else begin
            next_s.state = auto_mode_framer_pkg::st_tx_body;
            next_s.cnt = '0;
            next_s.tx_octet = s.mem[0] & auto_mode_framer_pkg::LEN_MASK;
            next_s.tx_last = (tx_len == auto_mode_framer_pkg::LEN_INVALID);
          end
        end
      end
      auto_mode_framer_pkg::st_tx_body: begin
        if (tx_ready) begin
          if (s.cnt[6:0] == tx_len) begin
            next_s.tx_last = 1'b0;
            next_s.tx_octet = '0;
            if (ack_req) begin
              next_s.state = auto_mode_framer_pkg::st_tx_ack_wait;
              next_s.timer = '0;
              next_s.cnt = '0;
              next_s.rx_len = '0;
            end else begin
              next_s.state = auto_mode_framer_pkg::st_tx_idle;
              next_s.result = auto_mode_framer_pkg::RESULT_SUCCESS;
              event_raw[auto_mode_framer_pkg::IRQ_TX_END] = 1'b1;
            end
          end else begin
            // Octet fetched only as the previous one leaves
            next_s.cnt = 8'(s.cnt + 8'h01);
            next_s.tx_octet = s.mem[7'(s.cnt[6:0] + 7'h01)];
            next_s.tx_last = (7'(s.cnt[6:0] + 7'h01) == tx_len);
          end
        end
      end
      auto_mode_framer_pkg::st_tx_ack_wait: begin
        next_s.timer = TW'(s.timer + 1'b1);
        // Ack octets are parsed, never written to the buffer
        if (rx_sfd) begin
          next_s.cnt = '0;
          next_s.rx_len = '0;
        end else if (rx_valid) begin
          if (s.cnt == 8'h00) begin
            next_s.rx_len = rx_octet[6:0];
          end else if (s.cnt == 8'h01) begin
            next_s.rx_fcf = rx_octet;
          end
          if (s.cnt[6:0] != auto_mode_framer_pkg::LEN_MAX) begin
            next_s.cnt = 8'(s.cnt + 8'h01);
          end
        end
        if (rx_end && rx_fcs_ok && rx_is_ack && s.rx_fcf[2:0] == auto_mode_framer_pkg::FRAME_TYPE_ACK) begin
          next_s.state = auto_mode_framer_pkg::st_tx_idle;
          event_raw[auto_mode_framer_pkg::IRQ_TX_END] = 1'b1;
          if (s.rx_fcf[auto_mode_framer_pkg::FCF_PENDING_BIT]) begin
            next_s.result = auto_mode_framer_pkg::RESULT_SUCCESS_MORE_DATA;
          end else begin
            next_s.result = auto_mode_framer_pkg::RESULT_SUCCESS;
          end
        end else if (s.timer == TW'(ACK_WAIT_CYCLES - 1)) begin
          if (s.retry < 4'(MAX_FRAME_RETRIES)) begin
            next_s.retry = 4'(s.retry + 4'h1);
            next_s.state = auto_mode_framer_pkg::st_tx_shr;
            next_s.cnt = '0;
            next_s.tx_octet = auto_mode_framer_pkg::PREAMBLE_OCTET;
          end else begin
            next_s.state = auto_mode_framer_pkg::st_tx_idle;
            next_s.result = auto_mode_framer_pkg::RESULT_NO_ACK;
            event_raw[auto_mode_framer_pkg::IRQ_TX_END] = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase

    if (reg_wr && reg_addr == auto_mode_framer_pkg::ADDR_STATE_CONTROL) begin
      if (reg_wdata == auto_mode_framer_pkg::CMD_OFF) begin
        next_s.state = auto_mode_framer_pkg::st_off;
        next_s.tx_last = 1'b0;
      end else if (reg_wdata == auto_mode_framer_pkg::CMD_AUTO_ACK_RECEIVE &&
                   (s.state == auto_mode_framer_pkg::st_off ||
                    s.state == auto_mode_framer_pkg::st_tx_idle)) begin
        next_s.state = auto_mode_framer_pkg::st_rx_idle;
        if (s.state == auto_mode_framer_pkg::st_off) begin
          event_raw[auto_mode_framer_pkg::IRQ_SYNTH_LOCK] = 1'b1;
        end
      end else if (reg_wdata == auto_mode_framer_pkg::CMD_AUTO_RETRY_TRANSMIT &&
                   (s.state == auto_mode_framer_pkg::st_off ||
                    s.state == auto_mode_framer_pkg::st_rx_idle)) begin
        next_s.state = auto_mode_framer_pkg::st_tx_idle;
        next_s.result = auto_mode_framer_pkg::RESULT_INVALID;
        if (s.state == auto_mode_framer_pkg::st_off) begin
          event_raw[auto_mode_framer_pkg::IRQ_SYNTH_LOCK] = 1'b1;
        end
      end else if (reg_wdata == auto_mode_framer_pkg::CMD_TX_START &&
                   s.state == auto_mode_framer_pkg::st_tx_idle) begin
        next_s.state = auto_mode_framer_pkg::st_tx_shr;
        next_s.cnt = '0;
        next_s.retry = '0;
        next_s.tx_octet = auto_mode_framer_pkg::PREAMBLE_OCTET;
      end
    end

    next_s.irq = event_raw & s.mask;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.mask <= auto_mode_framer_pkg::MASK_RESET;
      s.result <= auto_mode_framer_pkg::RESULT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign tx_octet = s.tx_octet;
  assign tx_last = s.tx_last;
  assign tx_valid = (s.state == auto_mode_framer_pkg::st_tx_shr) ||
                    (s.state == auto_mode_framer_pkg::st_tx_body);
  assign synth_lock_irq = s.irq[auto_mode_framer_pkg::IRQ_SYNTH_LOCK];
  assign receive_start_irq = s.irq[auto_mode_framer_pkg::IRQ_RX_START];
  assign address_match_irq = s.irq[auto_mode_framer_pkg::IRQ_ADDR_MATCH];
  assign receive_end_irq = s.irq[auto_mode_framer_pkg::IRQ_RX_END];
  assign transmit_end_irq = s.irq[auto_mode_framer_pkg::IRQ_TX_END];
endmodule

// ### design/auto_mode_framer_pkg.sv
package auto_mode_framer_pkg;
  localparam logic [7:0] ADDR_STATE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATE_REPORT = 8'h01;
  localparam logic [7:0] ADDR_RESULT = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
  localparam int FBUF_SELECT_BIT = 7;
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] CMD_AUTO_ACK_RECEIVE = 8'h01;
  localparam logic [7:0] CMD_AUTO_RETRY_TRANSMIT = 8'h02;
  localparam logic [7:0] CMD_TX_START = 8'h03;
  localparam logic [7:0] REPORT_OFF = 8'h00;
  localparam logic [7:0] REPORT_RX_IDLE = 8'h01;
  localparam logic [7:0] REPORT_RX_BUSY = 8'h02;
  localparam logic [7:0] REPORT_TX_IDLE = 8'h03;
  localparam logic [7:0] REPORT_TX_BUSY = 8'h04;
  localparam logic [2:0] RESULT_SUCCESS = 3'h0;
  localparam logic [2:0] RESULT_SUCCESS_MORE_DATA = 3'h1;
  localparam logic [2:0] RESULT_CHANNEL_FAIL = 3'h3;
  localparam logic [2:0] RESULT_NO_ACK = 3'h5;
  localparam logic [2:0] RESULT_INVALID = 3'h7;
  localparam logic [2:0] RESULT_RESET = RESULT_INVALID;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam int IRQ_SYNTH_LOCK = 0;
  localparam int IRQ_RX_START = 1;
  localparam int IRQ_ADDR_MATCH = 2;
  localparam int IRQ_RX_END = 3;
  localparam int IRQ_TX_END = 4;
  localparam logic [7:0] PREAMBLE_OCTET = 8'h00;
  localparam logic [7:0] PREAMBLE_OCTETS = 8'h04;
  localparam logic [7:0] SFD_OCTET = 8'ha7;
  localparam logic [7:0] LEN_MASK = 8'h7f;
  localparam logic [6:0] LEN_INVALID = 7'h00;
  localparam logic [6:0] LEN_ACK = 7'h05;
  localparam logic [6:0] LEN_MPDU_MIN = 7'h09;
  localparam logic [6:0] LEN_MAX = 7'h7f;
  localparam int FCF_PENDING_BIT = 4;
  localparam int FCF_ACK_REQ_BIT = 5;
  localparam logic [2:0] FRAME_TYPE_ACK = 3'h2;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SYMBOL_PS = 16000000;
  localparam int ACK_WAIT_SYMBOLS = 54;
  localparam int ACK_WAIT_CYCLES = ACK_WAIT_SYMBOLS * (SYMBOL_PS / CLK_PERIOD_PS);
  localparam int MAX_FRAME_RETRIES_DEFAULT = 3;
  typedef enum logic [2:0] {
    st_off,
    st_rx_idle,
    st_rx_busy,
    st_tx_idle,
    st_tx_shr,
    st_tx_body,
    st_tx_ack_wait
  } radio_state_t;
endpackage

// ### tb/auto_mode_framer_props.sv
`timescale 1ns/1ps
module auto_mode_framer_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] tx_octet,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_octet,
  input wire logic rx_end,
  input wire logic rx_fcs_ok,
  input wire logic synth_lock_irq,
  input wire logic receive_start_irq,
  input wire logic address_match_irq,
  input wire logic receive_end_irq,
  input wire logic transmit_end_irq
);
  logic [4:0] irqv;
  logic [4:0] mask_sh;
  logic [7:0] tx_n;
  logic ctl_wr;
  logic phr_ok_q;
  logic end_ok_q;
  assign irqv = {transmit_end_irq, receive_end_irq, address_match_irq, receive_start_irq,
    synth_lock_irq};
  assign ctl_wr = reg_wr && reg_addr == 8'h00;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_sh <= 5'h00;
      tx_n <= 8'h00;
      phr_ok_q <= 1'b0;
      end_ok_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h03) begin
        mask_sh <= reg_wdata[4:0];
      end
      tx_n <= tx_valid ? tx_n + 8'(tx_ready) : 8'h00;
      // Ack length excluded, acks never announce a reception
      phr_ok_q <= rx_valid && rx_octet[6:0] != 7'h00 && rx_octet[6:0] != 7'h05;
      end_ok_q <= rx_end && rx_fcs_ok;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_irq_masked: assert property ((irqv & ~mask_sh) == 5'h00)
    else $error("interrupt raised while masked");
  a_irq_pulse: assert property (irqv != 5'h00 |=> (irqv & $past(irqv)) == 5'h00)
    else $error("interrupt longer than one cycle");
  a_preamble_zero: assert property (tx_valid && tx_n < 8'h04 |-> tx_octet == 8'h00)
    else $error("preamble octet not zero");
  a_sfd_value: assert property (tx_valid && tx_n == 8'h04 |-> tx_octet == 8'ha7)
    else $error("delimiter octet wrong");
  a_phr_msb_zero: assert property (tx_valid && tx_n == 8'h05 |-> !tx_octet[7])
    else $error("length header msb set");
  a_octet_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_octet))
    else $error("octet changed before acceptance");
  a_lock_cause: assert property (synth_lock_irq |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("lock pulse without mode command");
  a_rx_start_cause: assert property (receive_start_irq |-> phr_ok_q)
    else $error("receive start without valid header");
  a_rx_end_cause: assert property (receive_end_irq |-> end_ok_q)
    else $error("receive end without good frame end");
  a_tx_end_idle: assert property (transmit_end_irq |-> !tx_valid)
    else $error("transmit end while still sending");
endmodule
bind auto_mode_framer auto_mode_framer_props u_props (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .tx_octet(tx_octet),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_octet(rx_octet),
  .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .synth_lock_irq(synth_lock_irq),
  .receive_start_irq(receive_start_irq), .address_match_irq(address_match_irq),
  .receive_end_irq(receive_end_irq), .transmit_end_irq(transmit_end_irq));

// ### tb/auto_mode_framer_tb.sv
`timescale 1ns/1ps
module auto_mode_framer_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stall = 1'b0;
  logic [7:0] reg_rdata, tx_octet, rx_octet, exp;
  logic tx_valid, tx_last, tx_ready, rx_sfd, rx_valid, rx_end, rx_fcs_ok, rx_addr_match;
  logic ack_tx_done;
  logic [4:0] irqv;
  logic [16:0] rows [10];
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n0;
  int last_n = 0;
  int cnt [5] = '{0, 0, 0, 0, 0};
  int base [5];
  always #2 sys_clk = ~sys_clk;
  auto_mode_framer #(.ACK_WAIT_CYCLES(50), .MAX_FRAME_RETRIES(1)) u_auto_mode_framer (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_octet(tx_octet),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .rx_sfd(rx_sfd),
    .rx_valid(rx_valid), .rx_octet(rx_octet), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok),
    .rx_addr_match(rx_addr_match), .ack_tx_done(ack_tx_done), .synth_lock_irq(irqv[0]),
    .receive_start_irq(irqv[1]), .address_match_irq(irqv[2]), .receive_end_irq(irqv[3]),
    .transmit_end_irq(irqv[4]));
  radio_peer_model u_peer (.sys_clk(sys_clk), .rst(rst), .tx_octet(tx_octet),
    .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready), .rx_sfd(rx_sfd),
    .rx_valid(rx_valid), .rx_octet(rx_octet), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok),
    .rx_addr_match(rx_addr_match), .ack_tx_done(ack_tx_done));
  task results;
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    for (int i = 0; i < 5; i++) cnt[i] += int'(irqv[i]);
    // Index of the octet that carried the last marker
    if (tx_valid && tx_ready && tx_last) last_n = u_peer.cap_n;
    if (cycles >= 20000) begin
      bad_count++;
      results();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, want);
  endtask
  // Interrupt counts since the last snapshot, one bit per line
  task chk5(input logic [4:0] want);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) check(8'(cnt[i] - base[i]), 8'(want[i]));
    base = cnt;
  endtask
  initial begin
    rows = '{17'h0_01_00, 17'h0_02_07, 17'h0_03_00, 17'h0_10_00, 17'h1_10_5a, 17'h0_10_00,
      17'h1_ff_3c, 17'h0_ff_3c, 17'h1_03_1f, 17'h0_03_1f};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
      else rd(rows[i][15:8], rows[i][7:0]);
    end
    base = cnt;
    wr(8'h00, 8'h02);
    chk5(5'b00001);
    rd(8'h02, 8'h07);
    rd(8'h01, 8'h03);
    wr(8'h80, 8'h09);
    for (int i = 1; i < 9; i++) wr(8'h80 + 8'(i), 8'(i));
    stall <= 1'b1;
    wr(8'h00, 8'h03);
    // Last octet written after start, must still go out
    wr(8'h89, 8'h99);
    rd(8'h01, 8'h04);
    wait (u_peer.cap_n == 15);
    chk5(5'b10000);
    for (int i = 0; i < 15; i++) begin
      exp = i < 4 ? 8'h00 : i == 4 ? 8'ha7 : i == 5 ? 8'h09 : i < 14 ? 8'(i - 5) : 8'h99;
      check(u_peer.cap[i], exp);
    end
    check(8'(last_n), 8'h0e);
    rd(8'h02, 8'h00);
    rd(8'h01, 8'h03);
    // Reserved msb set on purpose, device must clear it
    wr(8'h80, 8'h89);
    wr(8'h81, 8'h21);
    stall <= 1'b0;
    wr(8'h00, 8'h03);
    wait (u_peer.cap_n == 30);
    check(u_peer.cap[20], 8'h09);
    check(8'(last_n), 8'h1d);
    rd(8'h01, 8'h04);
    u_peer.send(8'h05, 8'h12, 1'b1, 1'b0);
    chk5(5'b10000);
    rd(8'h02, 8'h01);
    rd(8'h01, 8'h03);
    n0 = u_peer.cap_n;
    wr(8'h00, 8'h03);
    wait (u_peer.cap_n == n0 + 30);
    repeat (60) @(posedge sys_clk);
    chk5(5'b10000);
    rd(8'h02, 8'h05);
    wr(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h01, 8'h01);
    u_peer.send(8'h8a, 8'h41, 1'b1, 1'b1);
    chk5(5'b01111);
    rd(8'h80, 8'h0a);
    u_peer.send(8'h00, 8'h41, 1'b1, 1'b1);
    chk5(5'b00000);
    u_peer.send(8'h0a, 8'h41, 1'b0, 1'b1);
    chk5(5'b00110);
    u_peer.send(8'h05, 8'h02, 1'b1, 1'b1);
    chk5(5'b00000);
    u_peer.ack_done();
    chk5(5'b10000);
    // Reset in mid-run must drop mode, mask and result
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h07);
    rd(8'h03, 8'h00);
    wr(8'h00, 8'h01);
    wr(8'h03, 8'h00);
    u_peer.send(8'h0a, 8'h41, 1'b1, 1'b1);
    u_peer.ack_done();
    chk5(5'b00000);
    results();
  end
endmodule

// ### tb/radio_peer_model.sv
`timescale 1ns/1ps
module radio_peer_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] tx_octet,
  input wire logic tx_valid,
  input wire logic stall,
  output logic tx_ready,
  output logic rx_sfd,
  output logic rx_valid,
  output logic [7:0] rx_octet,
  output logic rx_end,
  output logic rx_fcs_ok,
  output logic rx_addr_match,
  output logic ack_tx_done
);
  logic [7:0] cap [0:511];
  int cap_n = 0;
  initial begin
    {tx_ready, rx_sfd, rx_valid, rx_end, rx_fcs_ok, rx_addr_match, ack_tx_done} = 7'h00;
    rx_octet = 8'h55;
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      // Stalling raises ready every other cycle, so each octet waits a cycle
      tx_ready <= stall ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        cap[cap_n] <= tx_octet;
        cap_n <= cap_n + 1;
      end
    end
  end
  task send(input logic [7:0] phr, input logic [7:0] fcf, input logic ok, input logic match);
    @(posedge sys_clk);
    rx_sfd <= 1'b1;
    @(posedge sys_clk);
    rx_sfd <= 1'b0;
    rx_valid <= 1'b1;
    rx_octet <= phr;
    for (int i = 0; i < int'(phr[6:0]); i++) begin
      @(posedge sys_clk);
      rx_octet <= (i == 0) ? fcf : 8'(i);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_octet <= ~rx_octet;
    rx_addr_match <= match;
    @(posedge sys_clk);
    rx_addr_match <= 1'b0;
    rx_end <= 1'b1;
    rx_fcs_ok <= ok;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    rx_fcs_ok <= 1'b0;
  endtask
  task ack_done;
    @(posedge sys_clk);
    ack_tx_done <= 1'b1;
    @(posedge sys_clk);
    ack_tx_done <= 1'b0;
  endtask
endmodule
